// ---- include/diag_flags_defines.svh ----
// constants for the diagnostic error-flag block: field positions,
// serial framing, crc and timing figures.
// assumes inclusion by bare name from the package and the rtl files.
`ifndef DIAG_FLAGS_DEFINES_SVH
`define DIAG_FLAGS_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_WIDTH          24
`define NUM_REGS           4
`define IDX_W              2
`define IDX_PAD            6
`define ADDR_W             6
`define STATUS_ADDR        6'h06
`define CTRL_IDX           2'h1
`define CTRL_FRAME_CRC_BIT 0
`define DEF_REG0           24'h000000
`define DEF_REG1           24'h000000
`define DEF_REG2           24'h000000
`define DEF_REG3           24'h000000

// ----------------------------------------------------------------
// error status bit positions
// ----------------------------------------------------------------
`define BIT_NEG_UV         12
`define BIT_REF_MISS       11
`define BIT_DLDO           9
`define BIT_ALDO           7
`define BIT_WR_BLOCK       6
`define BIT_SCLK_CNT       5
`define BIT_READ           4
`define BIT_LINK_CRC       2
`define BIT_MAP_CRC        1
`define BIT_ROM_CRC        0
`define STICKY_MASK        24'h001AB7

// ----------------------------------------------------------------
// serial framing
// ----------------------------------------------------------------
`define CMD_READ_BIT       6
`define CNT_W              6
`define CNT_MAX            6'h3F
`define SHIFT_W            40
`define CMD_BITS           6'h08
`define FRAME_BITS         6'h20
`define FRAME_CRC_BITS     6'h28
`define BYTE_REM_W         3

// ----------------------------------------------------------------
// crc and timing
// ----------------------------------------------------------------
`define CRC_W              8
`define CRC_POLY           8'h07
`define CRC_INIT           8'h00
`define TIMER_W            32
`define CLK_PERIOD_NS      50
`define CHECK_PERIOD_NS    1000000

`endif

// ---- include/diag_flags_pkg.sv ----
// types for the diagnostic error-flag block.
// assumes the defines header is on the include path.
package diag_flags_pkg;
  `include "diag_flags_defines.svh"

  typedef enum logic [1:0] {ROM_SCAN, IDLE, REF_SCAN, CHECK_SCAN}
    scan_state_type;

  typedef struct packed {
    logic                                   sclk_q;
    logic                                   cs_n_q;
    logic [`CNT_W-1:0]                      bit_cnt;
    logic [`SHIFT_W-1:0]                    shift_in;
    logic [`REG_WIDTH-1:0]                  shift_out;
    logic                                   dout;
    logic                                   rd_cmd;
    logic [`NUM_REGS-1:0][`REG_WIDTH-1:0]   regs;
    logic [`REG_WIDTH-1:0]                  err;
    scan_state_type                         scan;
    logic [`IDX_W-1:0]                      idx;
    logic [`CRC_W-1:0]                      crc_acc;
    logic [`CRC_W-1:0]                      ref_crc;
    logic [`TIMER_W-1:0]                    timer;
  } state_type;
endpackage : diag_flags_pkg

// ---- rtl/pin_sync.sv ----
// two-stage synchroniser bank for pins from outside the ref_clk domain.
// assumes ref_clk, nrst and clk_en of the enclosing block.
`timescale 1ns/1ps
module pin_sync #(
  parameter int                 WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type st;
  sync_state_type next_st;

  // meta feeds only the second stage
  always_comb begin
    next_st.meta   = d;
    next_st.stable = st.meta;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= {RESET_VAL, RESET_VAL};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign q = st.stable;
endmodule : pin_sync

// ---- rtl/diag_error_flags.sv ----
// diagnostic error flags, register map crc guard and serial slave.
// assumes a host as serial master (sclk idles high, data sampled on
// the rising edge) and analog detectors giving active-high levels.
//
// Overview of operation
// - set bit 12 when the negative analog input is undervoltage.
// - set bit 11 when the selected reference is open or below 0.7 V.
// - set bit 9 on a digital regulator fault.
// - set bit 7 on an analog regulator fault.
// - discard every register write while the register crc check runs.
// - bit 6 is high exactly while the register crc check runs.
// - set bit 5 when a frame's clock count is not a multiple of 8 or is 64 or more.
// - set bit 4 when a serial read fails.
// - set bit 2 when a frame's checksum does not match.
// - after each register write, compute and keep a reference crc.
// - recheck the map crc periodically; set bit 1 on mismatch.
// - at power-up check the default-value rom crc; set bit 0 on fault.
`timescale 1ns/1ps
`include "diag_flags_defines.svh"
module diag_error_flags
  import diag_flags_pkg::*;
#(
  parameter int unsigned     check_period_cycles =
    `CHECK_PERIOD_NS / `CLK_PERIOD_NS,
  parameter logic [`CRC_W-1:0] rom_ref_crc = rom_crc()
) (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   din,
  output logic                        dout,
  input  wire logic                   neg_input_undervoltage_det,
  input  wire logic                   reference_missing_det,
  input  wire logic                   digital_regulator_fault_det,
  input  wire logic                   analog_regulator_fault_det,
  output logic [`REG_WIDTH-1:0]       error_status
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [`CRC_W-1:0] crc8_word(
    input logic [`CRC_W-1:0] crc_in,
    input logic [31:0]       data
  );
    logic [`CRC_W-1:0] c;
    logic              fb;
    c = crc_in;
    for (int i = 31; i >= 0; i--) begin
      fb = c[`CRC_W-1] ^ data[i];
      c  = {c[`CRC_W-2:0], 1'b0};
      if (fb) begin
        c = c ^ `CRC_POLY;
      end
    end
    return c;
  endfunction : crc8_word

  function automatic logic [`REG_WIDTH-1:0] rom_value(
    input logic [`IDX_W-1:0] idx
  );
    logic [`REG_WIDTH-1:0] v;
    v = `DEF_REG0;
    unique case (idx)
      2'h0: v = `DEF_REG0;
      2'h1: v = `DEF_REG1;
      2'h2: v = `DEF_REG2;
      2'h3: v = `DEF_REG3;
    endcase
    return v;
  endfunction : rom_value

  // map entries carry their index so swapped words also show up
  function automatic logic [31:0] scan_word(
    input logic [`IDX_W-1:0]     idx,
    input logic [`REG_WIDTH-1:0] value
  );
    return {{`IDX_PAD{1'b0}}, idx, value};
  endfunction : scan_word

  function automatic logic [`CRC_W-1:0] rom_crc();
    logic [`CRC_W-1:0] c;
    c = `CRC_INIT;
    for (int i = 0; i < `NUM_REGS; i++) begin
      c = crc8_word(c, scan_word(`IDX_W'(i), rom_value(`IDX_W'(i))));
    end
    return c;
  endfunction : rom_crc

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pins_sync;
  logic       sclk_s;
  logic       cs_n_s;
  logic       din_s;
  logic       uv_s;
  logic       ref_s;
  logic       dldo_s;
  logic       aldo_s;

  // cs_n and sclk idle high so no false frame is seen after reset
  pin_sync #(
    .WIDTH     (7),
    .RESET_VAL (7'h03)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .d       ({analog_regulator_fault_det, digital_regulator_fault_det,
                reference_missing_det, neg_input_undervoltage_det,
                din, cs_n, sclk}),
    .q       (pins_sync)
  );

  assign {aldo_s, dldo_s, ref_s, uv_s, din_s, cs_n_s, sclk_s} = pins_sync;

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  state_type st;
  state_type next_st;

  always_comb begin
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    frame_on;
    logic                    frame_end;
    logic                    clear_rd;
    logic                    crc_on;
    logic                    crc_ok;
    logic [`REG_WIDTH-1:0]   set;
    logic [7:0]              cmd;
    logic [`REG_WIDTH-1:0]   wdata;
    logic [`CNT_W-1:0]       expect_bits;
    logic [`CRC_W-1:0]       c;
    logic [`REG_WIDTH-1:0]   value;
    sclk_rise   = sclk_s && !st.sclk_q;
    sclk_fall   = !sclk_s && st.sclk_q;
    frame_on    = !cs_n_s;
    frame_end   = cs_n_s && !st.cs_n_q;
    clear_rd    = 1'b0;
    crc_on      = st.regs[`CTRL_IDX][`CTRL_FRAME_CRC_BIT];
    crc_ok      = 1'b1;
    set         = '0;
    cmd         = '0;
    wdata       = '0;
    expect_bits = `FRAME_BITS;
    c           = '0;
    value       = '0;
    next_st     = st;
    next_st.sclk_q = sclk_s;
    next_st.cs_n_q = cs_n_s;

    set[`BIT_NEG_UV]   = uv_s;
    set[`BIT_REF_MISS] = ref_s;
    set[`BIT_DLDO]     = dldo_s;
    set[`BIT_ALDO]     = aldo_s;

    // scan engine: one map word per cycle
    unique case (st.scan)
      IDLE: begin
        next_st.timer = st.timer + `TIMER_W'(1);
        if (st.timer == `TIMER_W'(check_period_cycles - 1)) begin
          next_st.scan    = CHECK_SCAN;
          next_st.timer   = '0;
          next_st.idx     = '0;
          next_st.crc_acc = `CRC_INIT;
        end
      end
      ROM_SCAN, REF_SCAN, CHECK_SCAN: begin
        value = (st.scan == ROM_SCAN) ? rom_value(st.idx)
                                      : st.regs[st.idx];
        c = crc8_word(st.crc_acc, scan_word(st.idx, value));
        next_st.crc_acc = c;
        next_st.idx     = st.idx + `IDX_W'(1);
        if (st.idx == `IDX_W'(`NUM_REGS - 1)) begin
          next_st.scan = IDLE;
          if (st.scan == ROM_SCAN) begin
            set[`BIT_ROM_CRC] = (c != rom_ref_crc);
            next_st.ref_crc   = c;
          end else if (st.scan == REF_SCAN) begin
            next_st.ref_crc = c;
          end else begin
            set[`BIT_MAP_CRC] = (c != st.ref_crc);
          end
        end
      end
    endcase

    // ----------------------------------------------------------------
    // serial slave
    // ----------------------------------------------------------------
    if (st.cs_n_q && !cs_n_s) begin
      next_st.bit_cnt = '0;
      next_st.rd_cmd  = 1'b0;
    end

    if (frame_on && sclk_rise) begin
      next_st.shift_in = {st.shift_in[`SHIFT_W-2:0], din_s};
      if (st.bit_cnt != `CNT_MAX) begin
        next_st.bit_cnt = st.bit_cnt + `CNT_W'(1);
      end
      if (st.bit_cnt == `CMD_BITS - `CNT_W'(1)) begin
        cmd = {st.shift_in[6:0], din_s};
        if (cmd[`CMD_READ_BIT]) begin
          next_st.rd_cmd = 1'b1;
          if (cmd[`ADDR_W-1:0] == `STATUS_ADDR) begin
            next_st.shift_out = st.err;
            clear_rd          = 1'b1;
          end else if (cmd[`ADDR_W-1:0] < `ADDR_W'(`NUM_REGS)) begin
            next_st.shift_out = st.regs[cmd[`IDX_W-1:0]];
          end else begin
            next_st.shift_out = '0;
            set[`BIT_READ]    = 1'b1;
          end
        end
      end
    end

    // first data bit goes out on the fall after the command byte
    if (frame_on && sclk_fall && st.rd_cmd) begin
      next_st.dout      = st.shift_out[`REG_WIDTH-1];
      next_st.shift_out = {st.shift_out[`REG_WIDTH-2:0], 1'b0};
    end

    if (frame_end) begin
      if (st.bit_cnt[`BYTE_REM_W-1:0] != '0) begin
        set[`BIT_SCLK_CNT] = 1'b1;
      end else if (!st.rd_cmd) begin
        if (crc_on) begin
          expect_bits = `FRAME_CRC_BITS;
          cmd         = st.shift_in[39:32];
          wdata       = st.shift_in[31:8];
          crc_ok = crc8_word(`CRC_INIT, {cmd, wdata})
                   == st.shift_in[`CRC_W-1:0];
        end else begin
          cmd   = st.shift_in[31:24];
          wdata = st.shift_in[`REG_WIDTH-1:0];
        end
        if (st.bit_cnt == expect_bits && !cmd[`CMD_READ_BIT]) begin
          if (!crc_ok) begin
            set[`BIT_LINK_CRC] = 1'b1;
          end else if (st.scan != IDLE) begin
            // write dropped, map untouched
            next_st.scan = st.scan;
          end else if (cmd[`ADDR_W-1:0] < `ADDR_W'(`NUM_REGS)) begin
            next_st.regs[cmd[`IDX_W-1:0]] = wdata;
            next_st.scan    = REF_SCAN;
            next_st.idx     = '0;
            next_st.crc_acc = `CRC_INIT;
            next_st.timer   = '0;
          end
        end
      end
    end

    if (!cs_n_s) begin
      next_st.dout = next_st.dout;
    end else begin
      next_st.dout = 1'b0;
    end

    // set wins over the clear of a status read
    next_st.err = ((clear_rd ? (st.err & ~`STICKY_MASK) : st.err)
                   | set) & `STICKY_MASK;
    next_st.err[`BIT_WR_BLOCK] = (next_st.scan == CHECK_SCAN);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st        <= '0;
      st.sclk_q <= 1'b1;
      st.cs_n_q <= 1'b1;
      st.scan   <= ROM_SCAN;
      st.crc_acc <= `CRC_INIT;
      st.regs   <= {`DEF_REG3, `DEF_REG2, `DEF_REG1, `DEF_REG0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign dout         = st.dout;
  assign error_status = st.err;
endmodule : diag_error_flags

// ---- testbench/diag_error_flags_sva.sv ----
// assertions on the pins of the diagnostic error-flag block.
// assumes one ref_clk domain and host frames with 4-cycle margins.
`timescale 1ns/1ps
`include "diag_flags_defines.svh"
module diag_error_flags_sva
  import diag_flags_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire logic                  clk_en,
  input wire logic                  sclk,
  input wire logic                  cs_n,
  input wire logic                  neg_input_undervoltage_det,
  input wire logic                  reference_missing_det,
  input wire logic                  digital_regulator_fault_det,
  input wire logic                  analog_regulator_fault_det,
  input wire logic [`REG_WIDTH-1:0] error_status
);
  logic       sclk_q;
  logic       cs_q;
  logic [5:0] rises;

  // raw-pin clock count; host margins keep it equal to the synced view
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b1;
      cs_q   <= 1'b1;
      rises  <= 6'h00;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
      if (!cs_n && cs_q) rises <= 6'h00;
      else if (!cs_n && sclk && !sclk_q) rises <= rises + 6'h01;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_odd_end;
    cs_n && !cs_q ##0 rises[2:0] != 3'h0;
  endsequence
  property p_sclk_count;
    s_odd_end |-> ##[1:6] error_status[5];
  endproperty
  property p_neg_uv;
    (neg_input_undervoltage_det && clk_en) [*4] |-> ##[0:2] error_status[12];
  endproperty
  property p_ref_miss;
    (reference_missing_det && clk_en) [*4] |-> ##[0:2] error_status[11];
  endproperty
  property p_dldo;
    (digital_regulator_fault_det && clk_en) [*4] |-> ##[0:2] error_status[9];
  endproperty
  property p_aldo;
    (analog_regulator_fault_det && clk_en) [*4] |-> ##[0:2] error_status[7];
  endproperty
  property p_unused_zero;
    error_status[23:13] == 11'h000 && !error_status[10] && !error_status[8]
      && !error_status[3];
  endproperty
  property p_block_bound;
    error_status[6] [*4] |=> !error_status[6];
  endproperty
  // sticky flags only fall while a status read is in its frame
  property p_sticky_hold;
    ($past(error_status) & ~error_status & `STICKY_MASK) != 24'h000000
      |-> !cs_n;
  endproperty
  property p_crc_at_end;
    $rose(error_status[2]) |-> cs_n;
  endproperty

  a_sclk_count: assert property (p_sclk_count)
    else $error("clock count flag missing");
  a_neg_uv: assert property (p_neg_uv)
    else $error("undervoltage flag missing");
  a_ref_miss: assert property (p_ref_miss)
    else $error("reference flag missing");
  a_dldo: assert property (p_dldo)
    else $error("digital regulator flag missing");
  a_aldo: assert property (p_aldo)
    else $error("regulator flag missing");
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused status bit set");
  a_block_bound: assert property (p_block_bound)
    else $error("write blocked flag too long");
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("sticky flag dropped outside read");
  a_crc_at_end: assert property (p_crc_at_end)
    else $error("link crc flag inside frame");
endmodule : diag_error_flags_sva

// ---- testbench/serial_host.sv ----
// host model: serial master of the block, eight ref_clk per bit.
// assumes the bench ref_clk; sclk idles high and stops between frames.
`timescale 1ns/1ps
module serial_host (
  input  wire logic ref_clk,
  input  wire logic dout,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  task automatic open_frame();
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : open_frame

  // callers pass whole bytes except on purpose
  task automatic shift(input logic [39:0] bits, input int n,
                       output logic [23:0] rd);
    rd = 24'h000000;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      sclk <= 1'b0;
      din  <= bits[39-i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      rd = {rd[22:0], dout};
    end
  endtask : shift

  task automatic close_frame(input int lead);
    repeat (lead) @(posedge ref_clk);
    cs_n <= 1'b1;
    // released line must not keep showing the last bit
    din  <= ~din;
    repeat (6) @(posedge ref_clk);
  endtask : close_frame
endmodule : serial_host

// ---- testbench/test_diag_error_flags.sv ----
// self-checking bench for the diagnostic error-flag block.
// assumes serial_host as link master and the checker bound below.
`timescale 1ns/1ps
module test_diag_error_flags;
  import diag_flags_pkg::*;
  localparam int pos [4] = '{12, 11, 9, 7};
  logic        ref_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        clk_en  = 1'b1;
  logic [3:0]  det     = 4'h0;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic [23:0] error_status;
  logic [23:0] rd;
  logic [23:0] mem [4];
  int          fails   = 0;
  int          n_tests = 0;

  always #25 ref_clk = ~ref_clk;

  serial_host host (.ref_clk(ref_clk), .dout(dout), .sclk(sclk),
                    .cs_n(cs_n), .din(din));
  diag_error_flags #(.check_period_cycles(1000)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout),
    .neg_input_undervoltage_det(det[0]), .reference_missing_det(det[1]),
    .digital_regulator_fault_det(det[2]),
    .analog_regulator_fault_det(det[3]), .error_status(error_status));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check24(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check24

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8

  task automatic reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    mem = '{default: 24'h000000};
  endtask : reset

  // mode 0 no crc byte, 1 good crc byte, 2 corrupted crc byte
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] data,
                      input int mode, output logic [23:0] got);
    logic [7:0] c;
    c = crc8({cmd, data}) ^ ((mode == 2) ? 8'hFF : 8'h00);
    host.open_frame();
    host.shift({cmd, data, c}, (mode == 0) ? 32 : 40, got);
    host.close_frame(4);
  endtask : xfer

  task automatic rd_reg(input logic [5:0] a);
    xfer({2'b01, a}, 24'h000000, 0, rd);
  endtask : rd_reg

  // waits for a periodic check to start
  task automatic wait_check();
    int i;
    i = 0;
    while (error_status[6] !== 1'b1 && i < 1400) begin
      @(negedge ref_clk);
      i++;
    end
    check24("write blocked flag", 24'h1, {23'h0, error_status[6]});
  endtask : wait_check

  // parked after a check so no write lands in one; status never written
  task automatic wr_reg(input logic [1:0] a, input logic [23:0] v,
                        input int mode);
    wait_check();
    xfer({6'h00, a}, v, mode, rd);
  endtask : wr_reg

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [5:0]  a;
    logic [23:0] v;
    v = 24'($urandom(32'hC79F7C73));
    reset();
    rd_reg(6'h06);
    check24("status after reset", 24'h0, rd);
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 6'h00 : 6'(k + 1);
      v = 24'($urandom);
      wr_reg(a[1:0], v, 0);
      mem[a[1:0]] = v;
      rd_reg(a);
      check24("register readback", v, rd);
    end
    wait_check();
    rd_reg(6'h06);
    check24("status after map checks", 24'h0, rd);
    $display("test write and map check done");
    host.open_frame();
    host.shift({8'h02, 24'($urandom), 8'h00}, 32, rd);
    wait_check();
    host.close_frame(0);
    rd_reg(6'h02);
    check24("write during check", mem[2], rd);
    $display("test write blocked done");
    host.open_frame();
    host.shift({8'h46, 32'h0}, 8 * $urandom_range(1, 4) +
               $urandom_range(1, 7), rd);
    host.close_frame(4);
    rd_reg(6'h06);
    check24("clock count flag", 24'h000020, rd);
    rd_reg(6'h06);
    check24("flag cleared by read", 24'h0, rd);
    $display("test clock count done");
    a = 6'($urandom_range(4, 63));
    if (a == 6'h06) a = 6'h05;
    rd_reg(a);
    check24("unmapped read data", 24'h0, rd);
    rd_reg(6'h06);
    check24("read fault flag", 24'h000010, rd);
    $display("test read fault done");
    wr_reg(2'h1, 24'h000001, 0);
    v = 24'($urandom);
    wr_reg(2'h0, v, 2);
    rd_reg(6'h06);
    check24("link crc flag", 24'h000004, rd);
    rd_reg(6'h00);
    check24("bad crc write dropped", mem[0], rd);
    wr_reg(2'h0, v, 1);
    rd_reg(6'h00);
    check24("good crc write", v, rd);
    wr_reg(2'h1, 24'h000000, 1);
    $display("test frame crc done");
    @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (20) @(posedge ref_clk);
    clk_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      det[k] <= 1'b1;
      repeat (10) @(posedge ref_clk);
      det[k] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd_reg(6'h06);
      check24("detector flag", 24'h1 << pos[k], rd);
      rd_reg(6'h06);
      check24("detector flag cleared", 24'h0, rd);
    end
    $display("test detectors done");
    reset();
    rd_reg(6'h00);
    check24("register after reset", 24'h0, rd);
    rd_reg(6'h06);
    check24("status after second reset", 24'h0, rd);
    $display("test second reset done");
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    finish_test();
  end
endmodule : test_diag_error_flags

bind diag_error_flags diag_error_flags_sva chk (
  .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .sclk(sclk),
  .cs_n(cs_n), .neg_input_undervoltage_det(neg_input_undervoltage_det),
  .reference_missing_det(reference_missing_det),
  .digital_regulator_fault_det(digital_regulator_fault_det),
  .analog_regulator_fault_det(analog_regulator_fault_det),
  .error_status(error_status));
